// *** hw/rms_sequencer.sv ***
// top of the radio mode sequencer with its apb register file
// assumes radio events are one-cycle pulses synchronous to pclk
`timescale 1ns/100ps
module rms_sequencer #(
  parameter int TICK_CYCLES = rms_pkg::TICK_CYC,
  parameter int FIFO_DEPTH = rms_pkg::FIFO_BYTES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic preamble_found,
  input wire logic sync_word_match,
  input wire logic packet_done_tx,
  output rms_pkg::rms_mode_e radio_mode,
  output logic rc_osc_only,
  output logic fifo_rewind,
  output logic seq_running,
  output logic irq
);
  rms_pkg::rms_cfg_s cfg_reg;
  rms_pkg::rms_state_e st_reg;
  rms_pkg::rms_state_e st_next;
  rms_pkg::rms_mode_e mode_reg;
  rms_pkg::rms_mode_e mode_next;
  logic rc_only_reg;
  logic rewind_reg;
  logic [4:0] mask_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg;
  logic [15:0] presc_reg;
  logic [rms_pkg::EV_NUM-1:0] ev_flags;
  logic t1_exp;
  logic t2_exp;
  logic rxto_exp;
  logic t1_run;
  logic t2_run;
  // apb decode
  wire logic setup = psel && !penable;
  wire logic wr = psel && penable && pwrite && pclken;
  wire logic wr_cfg1 = wr && paddr == rms_pkg::OFS_SEQ_CFG1;
  wire logic wr_cfg2 = wr && paddr == rms_pkg::OFS_SEQ_CFG2;
  wire logic wr_t1 = wr && paddr == rms_pkg::OFS_FIRST_INTERVAL_TIMER;
  wire logic wr_t2 = wr && paddr == rms_pkg::OFS_SECOND_INTERVAL_TIMER;
  wire logic wr_rxto = wr && paddr == rms_pkg::OFS_RX_TIMEOUT;
  wire logic wr_pkt = wr && paddr == rms_pkg::OFS_PKT_CFG2;
  wire logic wr_stat = wr && paddr == rms_pkg::OFS_IRQ_STAT;
  wire logic wr_mask = wr && paddr == rms_pkg::OFS_IRQ_MASK;
  wire logic start_wr = wr_cfg1 && pwdata[rms_pkg::B_SEQ_START];
  wire logic halt_wr = wr_cfg1 && pwdata[rms_pkg::B_SEQ_HALT];
  wire logic mapped = paddr == rms_pkg::OFS_SEQ_CFG1 || paddr == rms_pkg::OFS_SEQ_CFG2 ||
                      paddr == rms_pkg::OFS_FIRST_INTERVAL_TIMER || paddr == rms_pkg::OFS_SECOND_INTERVAL_TIMER ||
                      paddr == rms_pkg::OFS_RX_TIMEOUT || paddr == rms_pkg::OFS_PKT_CFG2 ||
                      paddr == rms_pkg::OFS_STATUS || paddr == rms_pkg::OFS_IRQ_STAT ||
                      paddr == rms_pkg::OFS_IRQ_MASK;

  wire logic [31:0] rd_cfg1 = {25'h0, cfg_reg.idle_transition_sel, cfg_reg.low_power_choice,
                               cfg_reg.start_transition_sel, cfg_reg.idle_state_select, 2'h0};
  wire logic [31:0] rd_cfg2 = {26'h0, cfg_reg.transmit_transition_sel,
                               cfg_reg.rx_timeout_transition_sel, cfg_reg.receive_transition_sel};
  wire logic [31:0] rd_pkt = {16'h0, cfg_reg.payload_byte_count, 7'h0,
                              cfg_reg.periodic_beacon_enable};
  wire logic [31:0] rd_stat = {24'h0, seq_running, st_reg, mode_reg};
  wire logic [31:0] rd_mux =
    (paddr == rms_pkg::OFS_SEQ_CFG1) ? rd_cfg1 :
    (paddr == rms_pkg::OFS_SEQ_CFG2) ? rd_cfg2 :
    (paddr == rms_pkg::OFS_FIRST_INTERVAL_TIMER) ? {24'h0, cfg_reg.first_interval_timer} :
    (paddr == rms_pkg::OFS_SECOND_INTERVAL_TIMER) ? {24'h0, cfg_reg.second_interval_timer} :
    (paddr == rms_pkg::OFS_RX_TIMEOUT) ? {24'h0, cfg_reg.receive_timeout} :
    (paddr == rms_pkg::OFS_PKT_CFG2) ? rd_pkt :
    (paddr == rms_pkg::OFS_STATUS) ? rd_stat :
    (paddr == rms_pkg::OFS_IRQ_STAT) ? {27'h0, ev_flags} :
    (paddr == rms_pkg::OFS_IRQ_MASK) ? {27'h0, mask_reg} : 32'h0;

  // read data is caught in setup so the answer comes from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      slverr_reg <= 1'b0;
    end else if (pclken && setup) begin
      prdata_reg <= rd_mux;
      slverr_reg <= !mapped;
    end
  end
  assign prdata = prdata_reg;
  assign pslverr = slverr_reg && psel && penable;
  assign pready = psel && penable && pclken;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg.idle_state_select <= rms_pkg::RST_IDLE_SLEEP;
      cfg_reg.start_transition_sel <= rms_pkg::RST_START_SEL;
      cfg_reg.low_power_choice <= rms_pkg::RST_LOW_POWER;
      cfg_reg.idle_transition_sel <= rms_pkg::RST_IDLE_SEL;
      cfg_reg.receive_transition_sel <= rms_pkg::RST_RX_SEL;
      cfg_reg.rx_timeout_transition_sel <= rms_pkg::RST_RXTO_SEL;
      cfg_reg.transmit_transition_sel <= rms_pkg::RST_TX_SEL;
      cfg_reg.first_interval_timer <= rms_pkg::RST_TIMER;
      cfg_reg.second_interval_timer <= rms_pkg::RST_TIMER;
      cfg_reg.receive_timeout <= rms_pkg::RST_TIMER;
      cfg_reg.periodic_beacon_enable <= rms_pkg::RST_BEACON;
      cfg_reg.payload_byte_count <= rms_pkg::RST_PAYLOAD;
      mask_reg <= rms_pkg::RST_IRQ_MASK;
    end else begin
      if (wr_cfg1) begin
        cfg_reg.idle_state_select <= pwdata[rms_pkg::B_IDLE_SLEEP];
        cfg_reg.start_transition_sel <= pwdata[rms_pkg::B_START_SEL +: 2];
        cfg_reg.low_power_choice <= pwdata[rms_pkg::B_LOW_POWER];
        cfg_reg.idle_transition_sel <= pwdata[rms_pkg::B_IDLE_SEL];
      end
      if (wr_cfg2) begin
        cfg_reg.receive_transition_sel <= pwdata[rms_pkg::B_RX_SEL +: 3];
        cfg_reg.rx_timeout_transition_sel <= pwdata[rms_pkg::B_RXTO_SEL +: 2];
        cfg_reg.transmit_transition_sel <= pwdata[rms_pkg::B_TX_SEL];
      end
      if (wr_t1) begin
        cfg_reg.first_interval_timer <= pwdata[7:0];
      end
      if (wr_t2) begin
        cfg_reg.second_interval_timer <= pwdata[7:0];
      end
      if (wr_rxto) begin
        cfg_reg.receive_timeout <= pwdata[7:0];
      end
      if (wr_pkt) begin
        cfg_reg.periodic_beacon_enable <= pwdata[rms_pkg::B_BEACON];
        cfg_reg.payload_byte_count <= pwdata[rms_pkg::B_PAYLOAD +: 8];
      end
      if (wr_mask) begin
        mask_reg <= pwdata[4:0];
      end
    end
  end

  // [R02] 64 us base tick, aligned to the sequencer start
  wire logic running = st_reg != rms_pkg::RMS_OFF;
  wire logic tick = running && presc_reg == 16'(TICK_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= 16'h0;
    end else if (pclken) begin
      presc_reg <= (!running || tick) ? 16'h0 : presc_reg + 16'h1;
    end
  end

  wire logic seq_go = !running && st_next != rms_pkg::RMS_OFF;
  wire logic seq_stop = st_next == rms_pkg::RMS_OFF;
  wire logic rx_end = st_reg == rms_pkg::RMS_RX && ((rxto_exp && !preamble_found) || t2_exp);
  wire logic rx_enter = st_next == rms_pkg::RMS_RX && (st_reg != rms_pkg::RMS_RX || rx_end);

  // [R04] [R09] period is first plus second timer
  rms_timer #(.W(8)) u_first_interval_timer (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .tick(tick),
    .start(seq_go || t2_exp),
    .stop(seq_stop),
    .load(cfg_reg.first_interval_timer),
    .expire(t1_exp),
    .running(t1_run)
  );
  rms_timer #(.W(8)) u_second_interval_timer (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .tick(tick),
    .start(t1_exp),
    .stop(seq_stop),
    .load(cfg_reg.second_interval_timer),
    .expire(t2_exp),
    .running(t2_run)
  );
  // preamble timeout, stopped once a preamble is seen
  rms_timer #(.W(8)) u_rx_timeout (
    .pclk(pclk),
    .presetn(presetn),
    .pclken(pclken),
    .tick(tick),
    .start(rx_enter),
    .stop(seq_stop || st_next != rms_pkg::RMS_RX || preamble_found),
    .load(cfg_reg.receive_timeout),
    .expire(rxto_exp),
    .running()
  );

  wire logic rx_stop = (cfg_reg.receive_transition_sel == rms_pkg::RX_STOP_SYNC &&
                        sync_word_match) ||
                       (cfg_reg.receive_transition_sel == rms_pkg::RX_STOP_PREAMBLE &&
                        preamble_found);
  always_comb begin
    st_next = st_reg;
    if (halt_wr) begin
      // [R07] the halt bit ends the loop from any state
      st_next = rms_pkg::RMS_OFF;
    end else begin
      case (st_reg)
        rms_pkg::RMS_OFF: begin
          if (start_wr) begin
            if (cfg_reg.start_transition_sel == rms_pkg::START_RX) begin
              st_next = rms_pkg::RMS_RX;
            end else if (cfg_reg.start_transition_sel == rms_pkg::START_TX) begin
              st_next = rms_pkg::RMS_TX;
            end else begin
              st_next = rms_pkg::RMS_LOWPWR;
            end
          end
        end
        rms_pkg::RMS_LOWPWR: begin
          // [R12] low power choice into idle
          st_next = cfg_reg.low_power_choice ? rms_pkg::RMS_IDLE : rms_pkg::RMS_OFF;
        end
        rms_pkg::RMS_IDLE: begin
          // [R12] first timer wakes idle
          if (t1_exp) begin
            st_next = cfg_reg.idle_transition_sel ? rms_pkg::RMS_RX : rms_pkg::RMS_TX;
          end
        end
        rms_pkg::RMS_RX: begin
          if (rx_stop) begin
            // [R01] selected sync or preamble match stops sequencer
            st_next = rms_pkg::RMS_OFF;
          end else if (rx_end) begin
            // [R10] timeout resumes polling
            case (cfg_reg.rx_timeout_transition_sel)
              rms_pkg::RXTO_RX: st_next = rms_pkg::RMS_RX;
              rms_pkg::RXTO_TX: st_next = rms_pkg::RMS_TX;
              rms_pkg::RXTO_LOWPWR: st_next = rms_pkg::RMS_LOWPWR;
              default: st_next = rms_pkg::RMS_OFF;
            endcase
          end
        end
        rms_pkg::RMS_TX: begin
          // [R05] [R06] packet sent goes to low power, or to receive with transmit selector 1
          if (packet_done_tx) begin
            st_next = cfg_reg.transmit_transition_sel ? rms_pkg::RMS_RX : rms_pkg::RMS_LOWPWR;
          end
        end
        default: st_next = rms_pkg::RMS_OFF;
      endcase
    end
  end

  // radio mode holds through low power step and after a stop
  assign mode_next =
    (st_next == rms_pkg::RMS_IDLE) ?
      (cfg_reg.idle_state_select ? rms_pkg::RMS_SLEEP : rms_pkg::RMS_STBY) :
    (st_next == rms_pkg::RMS_RX) ? rms_pkg::RMS_MRX :
    (st_next == rms_pkg::RMS_TX) ? rms_pkg::RMS_MTX : mode_reg;

  wire logic tx_enter = st_next == rms_pkg::RMS_TX && st_reg != rms_pkg::RMS_TX;
  wire logic beacon_ok = cfg_reg.periodic_beacon_enable &&
                         32'(cfg_reg.payload_byte_count) < 32'(FIFO_DEPTH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= rms_pkg::RMS_OFF;
      mode_reg <= rms_pkg::RMS_SLEEP;
      rc_only_reg <= 1'b0;
      rewind_reg <= 1'b0;
    end else if (pclken) begin
      st_reg <= st_next;
      mode_reg <= mode_next;
      // [R11] sleep idle keeps only rc oscillator
      rc_only_reg <= st_next == rms_pkg::RMS_IDLE && cfg_reg.idle_state_select;
      // [R08] rewind fifo to resend payload
      rewind_reg <= tx_enter && beacon_ok;
    end
  end

  assign radio_mode = mode_reg;
  assign rc_osc_only = rc_only_reg;
  assign fifo_rewind = rewind_reg;
  assign seq_running = running;

  wire logic [rms_pkg::EV_NUM-1:0] ev_set = {
    running && seq_stop,
    rx_end,
    st_reg == rms_pkg::RMS_RX && preamble_found,
    st_reg == rms_pkg::RMS_RX && sync_word_match,
    st_reg == rms_pkg::RMS_TX && packet_done_tx
  };

  rms_sticky #(.W(rms_pkg::EV_NUM)) u_events (
    .pclk(pclk),
    .presetn(presetn),
    .set(pclken ? ev_set : '0),
    .clr(wr_stat ? pwdata[rms_pkg::EV_NUM-1:0] : '0),
    .flags(ev_flags)
  );
  assign irq = |(ev_flags & mask_reg);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SYNC_STOP: assert property ( // [R01]
    st_reg == rms_pkg::RMS_RX && cfg_reg.receive_transition_sel == rms_pkg::RX_STOP_SYNC &&
    sync_word_match && pclken |=> st_reg == rms_pkg::RMS_OFF && radio_mode == rms_pkg::RMS_MRX)
    else $error("sync match did not stop the sequencer in receive");
  AST_TICK_ALIGN: assert property ( // [R02]
    t1_exp |-> presc_reg == 16'(TICK_CYCLES - 1) && $past(running))
    else $error("first timer expired off the base tick");
  AST_T2_FOLLOWS_T1: assert property ( // [R04]
    t1_exp && !seq_stop |=> t2_run && !t1_run)
    else $error("second timer not started by first timer expiry");
  AST_T1_FOLLOWS_T2: assert property ( // [R09]
    t2_exp && !seq_stop |=> t1_run && !t2_run)
    else $error("first timer not restarted by second timer expiry");
  AST_TX_TO_LOWPWR: assert property ( // [R06]
    st_reg == rms_pkg::RMS_TX && !cfg_reg.transmit_transition_sel && packet_done_tx &&
    pclken && !halt_wr |=> st_reg == rms_pkg::RMS_LOWPWR)
    else $error("packet sent did not leave transmit");
  AST_IDLE_WAKE: assert property ( // [R12]
    st_reg == rms_pkg::RMS_IDLE && t1_exp && !halt_wr |=>
    st_reg == ($past(cfg_reg.idle_transition_sel) ? rms_pkg::RMS_RX : rms_pkg::RMS_TX))
    else $error("idle did not wake on first timer");
  AST_RX_TIMEOUT: assert property ( // [R10]
    st_reg == rms_pkg::RMS_RX && t2_exp && !rx_stop && !halt_wr &&
    cfg_reg.rx_timeout_transition_sel == rms_pkg::RXTO_LOWPWR |=> st_reg == rms_pkg::RMS_LOWPWR)
    else $error("second timer end did not leave receive");
  AST_HALT: assert property ( // [R07]
    halt_wr |=> st_reg == rms_pkg::RMS_OFF && !seq_running)
    else $error("halt bit did not stop the sequencer");
  AST_BEACON_REWIND: assert property ( // [R08]
    tx_enter && beacon_ok && pclken |=> fifo_rewind ##1 !fifo_rewind || !pclken)
    else $error("beacon payload not rewound on transmit");
  AST_SLEEP_RC: assert property ( // [R11]
    st_reg == rms_pkg::RMS_IDLE && $past(cfg_reg.idle_state_select) && $past(pclken) |->
    rc_osc_only && radio_mode == rms_pkg::RMS_SLEEP)
    else $error("sleep idle without rc only");
endmodule

// *** hw/rms_pkg.sv ***
// constants, layouts and types of the radio mode sequencer
// assumes a 25 MHz pclk and an APB master with 32-bit data
// Functional notes
// [R01] with receive selector 101 a sync word match stops the sequencer and leaves the radio in receive.
// [R02] the first interval timer has a least duration of 64 us, the base unit of all timers.
// [R03] software sets the preamble receive timeout just long enough to catch a preamble.
// [R04] in listen use, reception starts are spaced by first plus second timer durations.
// [R05] in beacon use the radio enters transmit once per period and returns to idle after the packet is sent.
// [R06] with transmit selector 0 a packet sent event moves the sequencer to the low power choice.
// [R07] once running the sequencer loops until software writes the halt bit of config register one; the code also stops on a selected sync or preamble stop.
// [R08] with beacon enabled and a payload count below the fifo capacity the same payload is resent each period.
// [R09] in beacon use one transmission start follows another after first plus second timer durations.
// [R10] with no sync match by the end of the second timer the radio leaves receive and polling resumes.
// [R11] an idle state chosen as sleep keeps only the low power rc oscillator running.
// [R12] on start the sequencer passes the low power choice into idle, and a first timer expiry in idle enters receive or transmit;
//       the code goes straight to receive or transmit on start with start selector 01 or 10.
package rms_pkg;

  // timing
  localparam int PCLK_NS = 40;
  localparam int TICK_NS = 64000;
  localparam int TICK_CYC = (TICK_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int FIFO_BYTES = 64;

  // register byte offsets
  localparam logic [7:0] OFS_SEQ_CFG1 = 8'h00;
  localparam logic [7:0] OFS_SEQ_CFG2 = 8'h04;
  localparam logic [7:0] OFS_FIRST_INTERVAL_TIMER = 8'h08;
  localparam logic [7:0] OFS_SECOND_INTERVAL_TIMER = 8'h0c;
  localparam logic [7:0] OFS_RX_TIMEOUT = 8'h10;
  localparam logic [7:0] OFS_PKT_CFG2 = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // sequencer_config_reg_one fields
  localparam int B_SEQ_START = 0;
  localparam int B_SEQ_HALT = 1;
  localparam int B_IDLE_SLEEP = 2;
  localparam int B_START_SEL = 3;
  localparam int B_LOW_POWER = 5;
  localparam int B_IDLE_SEL = 6;
  // sequencer_config_reg_two fields
  localparam int B_RX_SEL = 0;
  localparam int B_RXTO_SEL = 3;
  localparam int B_TX_SEL = 5;
  // packet_config_reg_two fields
  localparam int B_BEACON = 0;
  localparam int B_PAYLOAD = 8;

  // reset values
  localparam logic RST_IDLE_SLEEP = 1'b1;
  localparam logic [1:0] RST_START_SEL = 2'h0;
  localparam logic RST_LOW_POWER = 1'b1;
  localparam logic RST_IDLE_SEL = 1'b1;
  localparam logic [2:0] RST_RX_SEL = 3'h0;
  localparam logic [1:0] RST_RXTO_SEL = 2'h0;
  localparam logic RST_TX_SEL = 1'b0;
  localparam logic [7:0] RST_TIMER = 8'h01;
  localparam logic RST_BEACON = 1'b0;
  localparam logic [7:0] RST_PAYLOAD = 8'h00;
  localparam logic [4:0] RST_IRQ_MASK = 5'h00;

  // selector codes
  localparam logic [2:0] RX_STOP_SYNC = 3'h5;
  localparam logic [2:0] RX_STOP_PREAMBLE = 3'h6;
  localparam logic [1:0] RXTO_RX = 2'h0;
  localparam logic [1:0] RXTO_TX = 2'h1;
  localparam logic [1:0] RXTO_LOWPWR = 2'h2;
  localparam logic [1:0] START_RX = 2'h1;
  localparam logic [1:0] START_TX = 2'h2;

  // interrupt status bits
  localparam int EV_TX_DONE = 0;
  localparam int EV_SYNC = 1;
  localparam int EV_PREAMBLE = 2;
  localparam int EV_RX_END = 3;
  localparam int EV_SEQ_OFF = 4;
  localparam int EV_NUM = 5;

  typedef enum logic [4:0] {
    RMS_OFF = 5'b00001,
    RMS_LOWPWR = 5'b00010,
    RMS_IDLE = 5'b00100,
    RMS_RX = 5'b01000,
    RMS_TX = 5'b10000
  } rms_state_e;

  typedef enum logic [1:0] {
    RMS_SLEEP = 2'b00,
    RMS_STBY = 2'b01,
    RMS_MRX = 2'b10,
    RMS_MTX = 2'b11
  } rms_mode_e;

  typedef struct packed {
    logic idle_state_select;
    logic [1:0] start_transition_sel;
    logic low_power_choice;
    logic idle_transition_sel;
    logic [2:0] receive_transition_sel;
    logic [1:0] rx_timeout_transition_sel;
    logic transmit_transition_sel;
    logic [7:0] first_interval_timer;
    logic [7:0] second_interval_timer;
    logic [7:0] receive_timeout;
    logic periodic_beacon_enable;
    logic [7:0] payload_byte_count;
  } rms_cfg_s;

endpackage

// *** hw/rms_timer.sv ***
// interval timer counting base ticks
// assumes tick spans one enabled cycle; the clock enable gates it here
`timescale 1ns/100ps
module rms_timer #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] load,
  output logic expire,
  output logic running
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire logic [W-1:0] load_min = (load == '0) ? W'(1) : load;

  // zero is treated as one unit, the shortest duration
  assign cnt_next = stop ? '0 : start ? load_min :
                    (tick && cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg;
  // no start or stop term, so no loop through the state logic
  assign expire = pclken && tick && cnt_reg == W'(1);
  assign running = cnt_reg != '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (pclken) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// *** hw/rms_sticky.sv ***
// sticky event bits, write one to clear
// assumes set and clear are already qualified by the clock enable
`timescale 1ns/100ps
module rms_sticky #(
  parameter int W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] flags
);
  logic [W-1:0] flags_reg;

  // a set in the clearing cycle wins, so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~clr) | set;
    end
  end
  assign flags = flags_reg;
endmodule

// *** test/rms_radio_model.sv ***
// behavioural radio answering the sequencer's mode output with events
// assumes events are sampled by the sequencer on pclk as one-cycle pulses
`timescale 1ns/100ps
module rms_radio_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] radio_mode,
  input wire logic [1:0] evt_mode,
  output logic preamble_found,
  output logic sync_word_match,
  output logic packet_done_tx
);
  logic [1:0] last_mode;
  int n;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_mode <= 2'h0;
      n <= 0;
      preamble_found <= 1'b0;
      sync_word_match <= 1'b0;
      packet_done_tx <= 1'b0;
    end else begin
      n <= (radio_mode == last_mode) ? n + 1 : 0;
      last_mode <= radio_mode;
      packet_done_tx <= (radio_mode == 2'h3) && (n == 2);
      preamble_found <= (radio_mode == 2'h2) && (n == 0) && (evt_mode != 2'h0);
      sync_word_match <= (radio_mode == 2'h2) && (n == 2) && (evt_mode == 2'h2);
    end
  end
endmodule

// *** test/test_radio_mode_sequencer.sv ***
// register-level bench of the radio mode sequencer with a radio model
// assumes a shortened tick of 4 cycles and a zero-wait apb slave
`timescale 1ns/100ps
module test_radio_mode_sequencer;
  localparam int TCYC = 4;
  localparam int PERIOD = 3 * TCYC;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, rc_osc_only, fifo_rewind, seq_running, irq;
  logic preamble_found, sync_word_match, packet_done_tx;
  logic [1:0] evt_mode = 2'h0;
  logic [1:0] pm = 2'h0;
  rms_pkg::rms_mode_e radio_mode;
  int bad_count = 0, tests_run = 0, cyc = 0, rew_cnt = 0, tx_cnt = 0, t0, t1, rw0;

  rms_sequencer #(.TICK_CYCLES(TCYC)) dut_u (.pclk(pclk), .presetn(presetn),
    .pclken(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .preamble_found(preamble_found), .sync_word_match(sync_word_match),
    .packet_done_tx(packet_done_tx), .radio_mode(radio_mode), .rc_osc_only(rc_osc_only),
    .fifo_rewind(fifo_rewind), .seq_running(seq_running), .irq(irq));
  rms_radio_model radio_u (.pclk(pclk), .presetn(presetn), .radio_mode(radio_mode),
    .evt_mode(evt_mode), .preamble_found(preamble_found),
    .sync_word_match(sync_word_match), .packet_done_tx(packet_done_tx));

  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    pm <= radio_mode;
    if (fifo_rewind === 1'b1) rew_cnt <= rew_cnt + 1;
    if (radio_mode === 2'h3 && pm !== 2'h3) tx_cnt <= tx_cnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // slow slave tolerated up to a bound
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_mode(input logic [1:0] m, output int t);
    int n;
    n = 0;
    @(posedge pclk);
    while (radio_mode !== m && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n == 400) chk("mode wait", 32'(radio_mode), 32'(m));
    t = cyc;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #(40 * 30000);
    bad_count++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, rms_pkg::OFS_SEQ_CFG1, 32'h0);
    chk("cfg1 reset", rd, 32'h64);
    apb(1'b0, rms_pkg::OFS_STATUS, 32'h0);
    chk("status reset", rd, 32'h04);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    $display("reset test done");
    apb(1'b1, rms_pkg::OFS_FIRST_INTERVAL_TIMER, 32'h1);
    apb(1'b1, rms_pkg::OFS_SECOND_INTERVAL_TIMER, 32'h2);
    apb(1'b1, rms_pkg::OFS_PKT_CFG2, 32'h0801);
    apb(1'b1, rms_pkg::OFS_IRQ_MASK, 32'h1);
    apb(1'b1, rms_pkg::OFS_SEQ_CFG1, 32'h25);
    wait_mode(2'h3, t0);
    wait_mode(2'h0, t1);
    @(posedge pclk);
    chk("sleep rc only", 32'(rc_osc_only), 32'h1);
    wait_mode(2'h3, t1);
    chk("tx spacing", 32'(t1 - t0), 32'(PERIOD));
    chk("irq tx done", 32'(irq), 32'h1);
    repeat (2) @(posedge pclk);
    chk("rewind count", 32'(rew_cnt), 32'(tx_cnt));
    // full fifo payload must not be replayed
    apb(1'b1, rms_pkg::OFS_PKT_CFG2, 32'h4001);
    rw0 = rew_cnt;
    wait_mode(2'h0, t1);
    wait_mode(2'h3, t1);
    repeat (3) @(posedge pclk);
    chk("no rewind", 32'(rew_cnt), 32'(rw0));
    chk("loop runs", 32'(seq_running), 32'h1);
    apb(1'b1, rms_pkg::OFS_SEQ_CFG1, 32'h26);
    @(posedge pclk);
    chk("halted", 32'(seq_running), 32'h0);
    apb(1'b1, rms_pkg::OFS_IRQ_STAT, 32'h1f);
    // flags clear at the write edge, seen one edge on
    @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("beacon test done");
    apb(1'b1, rms_pkg::OFS_RX_TIMEOUT, 32'h1);
    apb(1'b1, rms_pkg::OFS_SEQ_CFG2, 32'h15);
    apb(1'b1, rms_pkg::OFS_SEQ_CFG1, 32'h65);
    wait_mode(2'h2, t0);
    for (int k = 0; k < 2; k++) begin
      evt_mode <= 2'(k);
      wait_mode(2'h0, t1);
      wait_mode(2'h2, t1);
      chk("rx spacing", 32'(t1 - t0), 32'(PERIOD));
      t0 = t1;
    end
    // sync only in a period that starts after the change
    wait_mode(2'h0, t1);
    evt_mode <= 2'h2;
    wait_mode(2'h2, t0);
    repeat (8) @(posedge pclk);
    chk("sync stop", 32'(seq_running), 32'h0);
    chk("stays rx", 32'(radio_mode), 32'h2);
    // start straight into receive, stop on preamble
    apb(1'b1, rms_pkg::OFS_SEQ_CFG2, 32'h16);
    apb(1'b1, rms_pkg::OFS_SEQ_CFG1, 32'h6c);
    apb(1'b1, rms_pkg::OFS_SEQ_CFG1, 32'h6d);
    wait_mode(2'h0, t1);
    wait_mode(2'h2, t0);
    repeat (8) @(posedge pclk);
    chk("preamble stop", 32'(seq_running), 32'h0);
    chk("preamble stays rx", 32'(radio_mode), 32'h2);
    $display("listen test done");
    final_report();
  end
endmodule
